// File: core/identify_capability_pkg.sv
/*
 * Constants, word indices and carrier types for the identification
 * capability words 63..84. Assumes a single 20 MHz clock domain.
 */
// Operation
// - word 63 high byte one-hot selected mode
// - bits 8..10 select modes 0..2, rest reserved
// - word 63 low byte cumulative support mask
// - supported timing fields raise word 53 bit 1
// - word 64 bit 1 mode 4, bit 0 mode 3
// - word 65 minimum DMA cycle, zero if unsupported
// - word 66 recommended cycle not below word 65
// - word 67 required for PIO 3+, not below 68
// - word 68 matches fastest supported PIO mode
// - unsupported PIO cycle words read zero
// - word 75 bits 4:0 hold depth minus one; the code always reads zero, as word 76 bit 6 is masked off
// - depth zero without queued or first-party DMA
// - word 76 serial link capability bits
// - word 78 supported serial feature bits 6..1
// - word 79 enabled bits, same positions
// - words 83,84 bit 14 one, bit 15 zero
// - word 82 fixed zero and one bits
// - word 82 bits 1,5,6 follow configuration
// - word 83 bit 0 set, 1,2,4 clear, 3 APM
package identify_capability_pkg;

    // ------------------------------------------------------------
    // word indices
    // ------------------------------------------------------------
    localparam logic [7:0] W_MDMA     = 8'h3F;
    localparam logic [7:0] W_APIO     = 8'h40;
    localparam logic [7:0] W_MDMA_MIN = 8'h41;
    localparam logic [7:0] W_MDMA_REC = 8'h42;
    localparam logic [7:0] W_PIO_NOFC = 8'h43;
    localparam logic [7:0] W_PIO_FC   = 8'h44;
    localparam logic [7:0] W_QDEPTH   = 8'h4B;
    localparam logic [7:0] W_SCAP     = 8'h4C;
    localparam logic [7:0] W_SFSUP    = 8'h4E;
    localparam logic [7:0] W_SFEN     = 8'h4F;
    localparam logic [7:0] W_CMDA     = 8'h52;
    localparam logic [7:0] W_CMDB     = 8'h53;
    localparam logic [7:0] W_CMDC     = 8'h54;

    // ------------------------------------------------------------
    // field layouts and fixed patterns
    // ------------------------------------------------------------
    localparam logic [15:0] CMDA_FIXED_ONE = 16'h7408;
    localparam logic [15:0] CMDA_CFG_MASK  = 16'h0062;
    localparam logic [15:0] CMDB_FIXED_ONE = 16'h4001;
    localparam logic [15:0] CMDC_FIXED_ONE = 16'h4000;
    localparam logic [15:0] APM_BIT        = 16'h0008;
    localparam logic [15:0] SCAP_MASK      = 16'h0706;
    localparam logic [15:0] SFEAT_MASK     = 16'h007E;
    localparam logic [15:0] MDMA_SEL_MASK  = 16'h0700;
    localparam logic [15:0] MDMA_SUP_MASK  = 16'h0007;
    localparam logic [15:0] APIO_MASK      = 16'h0003;
    localparam logic [15:0] QDEPTH_MASK    = 16'h001F;
    localparam int          FPDMA_BIT      = 6;
    localparam int          W53_TIMING_BIT = 1;
    localparam logic [15:0] WORD_ZERO      = 16'h0000;

    // ------------------------------------------------------------
    // drive configuration carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  mdmaSupport;   // cumulative support mask
        logic [1:0]  mdmaSelect;    // selected mode index
        logic        mdmaSelValid;  // a multiword mode is selected
        logic [1:0]  pioAdvanced;   // bit1 mode 4, bit0 mode 3
        logic [15:0] mdmaMinNs;
        logic [15:0] mdmaRecNs;
        logic [15:0] pioNoFlowNs;
        logic [15:0] pioFlowNs;
        logic [4:0]  queueDepthM1;
        logic [15:0] serialCaps;
        logic [15:0] serialSup;
        logic [15:0] serialEn;
        logic        securitySup;
        logic        writeCacheSup;
        logic        lookAheadSup;
        logic        apmSup;
    } drive_cfg_t;

endpackage : identify_capability_pkg

// File: core/identify_capability_words.sv
/*
 * Read-only capability identification words 63..84. Firmware holds
 * the drive configuration steady on cfg; the block decodes cfg
 * combinationally and answers word reads by index one cycle later.
 * Assumes cfg and the read port are on clk; no writes exist.
 */
`timescale 1ns/10ps
module identify_capability_words
    import identify_capability_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    // drive configuration
    input  wire drive_cfg_t  cfg,
    // word read port
    input  wire logic        rdEn,
    input  wire logic [7:0]  rdIndex,
    output logic [15:0]      rdData_r,
    output logic             rdValid_r,
    // timing words valid flag for word 53
    output logic             timingValid_r
);

    // ------------------------------------------------------------
    // word assembly
    // ------------------------------------------------------------
    logic        pioSup;
    logic        mdmaSup;
    logic [2:0]  selOneHot;
    logic [15:0] wMdma;
    logic [15:0] wApio;
    logic [15:0] wMdmaMin;
    logic [15:0] wMdmaRec;
    logic [15:0] wPioNoFc;
    logic [15:0] wPioFc;
    logic [15:0] wQdepth;
    logic [15:0] wScap;
    logic [15:0] wSfSup;
    logic [15:0] wSfEn;
    logic [15:0] wCmdA;
    logic [15:0] wCmdB;
    logic [15:0] wCmdC;
    logic [15:0] rdData_nxt;
    logic        timingValid_nxt;

    assign pioSup  = |cfg.pioAdvanced;
    assign mdmaSup = |cfg.mdmaSupport;

    // one-hot selection, at most one bit
    assign selOneHot = cfg.mdmaSelValid ?
                       3'(3'h1 << cfg.mdmaSelect) : 3'h0;

    // cumulative support mask in low bits
    assign wMdma = ({5'h00, selOneHot, 8'h00} & MDMA_SEL_MASK)
                 | ({13'h0000, cfg.mdmaSupport} & MDMA_SUP_MASK);

    // advanced PIO modes 3 and 4
    assign wApio = {14'h0000, cfg.pioAdvanced} & APIO_MASK;

    // minimum DMA cycle, zero when unsupported
    assign wMdmaMin = mdmaSup ? cfg.mdmaMinNs : WORD_ZERO;

    assign wMdmaRec = !mdmaSup ? WORD_ZERO :
                      (cfg.mdmaRecNs < wMdmaMin) ? wMdmaMin :
                      cfg.mdmaRecNs;

    assign wPioFc = pioSup ? cfg.pioFlowNs : WORD_ZERO;

    // no-flow cycle never below flow cycle
    assign wPioNoFc = !pioSup ? WORD_ZERO :
                      (cfg.pioNoFlowNs < wPioFc) ? wPioFc :
                      cfg.pioNoFlowNs;

    // timing words present raise word 53 bit 1
    assign timingValid_nxt = mdmaSup | pioSup;

    // serial capability bits, bit 0 zero
    assign wScap = cfg.serialCaps & SCAP_MASK;

    // bits 4:0 always zero: word 76 bit 6 is outside SCAP_MASK
    // zero without first-party or queued DMA
    assign wQdepth = (wScap[FPDMA_BIT] && wCmdB[1]) ?
                     ({11'h000, cfg.queueDepthM1} & QDEPTH_MASK) :
                     WORD_ZERO;

    assign wSfSup = cfg.serialSup & SFEAT_MASK;

    assign wSfEn = cfg.serialEn & SFEAT_MASK;

    assign wCmdA = CMDA_FIXED_ONE
                 | ({9'h000, cfg.lookAheadSup, cfg.writeCacheSup,
                     3'h0, cfg.securitySup, 1'b0} & CMDA_CFG_MASK);

    assign wCmdB = CMDB_FIXED_ONE | (cfg.apmSup ? APM_BIT : WORD_ZERO);
    assign wCmdC = CMDC_FIXED_ONE;

    // unmapped and reserved words read zero
    always_comb begin
        case (rdIndex)
            W_MDMA:     rdData_nxt = wMdma;
            W_APIO:     rdData_nxt = wApio;
            W_MDMA_MIN: rdData_nxt = wMdmaMin;
            W_MDMA_REC: rdData_nxt = wMdmaRec;
            W_PIO_NOFC: rdData_nxt = wPioNoFc;
            W_PIO_FC:   rdData_nxt = wPioFc;
            W_QDEPTH:   rdData_nxt = wQdepth;
            W_SCAP:     rdData_nxt = wScap;
            W_SFSUP:    rdData_nxt = wSfSup;
            W_SFEN:     rdData_nxt = wSfEn;
            W_CMDA:     rdData_nxt = wCmdA;
            W_CMDB:     rdData_nxt = wCmdB;
            W_CMDC:     rdData_nxt = wCmdC;
            default:    rdData_nxt = WORD_ZERO;
        endcase
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    // no write path exists, so host traffic cannot alter any word
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdData_r      <= WORD_ZERO;
            rdValid_r     <= 1'b0;
            timingValid_r <= 1'b0;
        end else if (clkEn) begin
            rdData_r      <= rdEn ? rdData_nxt : WORD_ZERO;
            rdValid_r     <= rdEn;
            timingValid_r <= timingValid_nxt;
        end
    end

endmodule : identify_capability_words

// File: test/identify_capability_asserts.sv
/* checks on the capability word block, bound to its top ports;
   one clock, synchronous active-low reset */
`timescale 1ns/10ps
module identify_capability_asserts
    import identify_capability_pkg::*;
(
    // control
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        clkEn,
    input wire drive_cfg_t  cfg,
    // read port
    input wire logic        rdEn,
    input wire logic [7:0]  rdIndex,
    input wire logic [15:0] rdData_r,
    input wire logic        rdValid_r,
    input wire logic        timingValid_r
);
    logic [7:0] lastIdx_r;
    // index 00 is unmapped, so it stands for no answer
    wire  [7:0] w = rdValid_r ? lastIdx_r : 8'h00;

    always_ff @(posedge clk) begin
        if (clkEn) lastIdx_r <= rdIndex;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_sel_onehot: assert property (
        w == W_MDMA |-> $onehot0(rdData_r[15:8]))
        else $error("selected mode field not one-hot");
    a_mdma_rsvd: assert property (
        w == W_MDMA |-> rdData_r[15:11] == 5'h00)
        else $error("reserved select bits set");
    a_timing_flag: assert property (
        w == W_MDMA && rdData_r[2:0] != 3'h0 |-> timingValid_r)
        else $error("timing flag low with dma support");
    a_rec_not_low: assert property (
        w == W_MDMA_REC && cfg.mdmaSupport != 3'h0
        |-> rdData_r >= cfg.mdmaMinNs)
        else $error("recommended cycle below minimum");
    a_depth_zero: assert property (
        w == W_QDEPTH |-> rdData_r == 16'h0000)
        else $error("queue depth not zero");
    a_sets_valid: assert property (
        w == W_CMDB || w == W_CMDC |-> rdData_r[15:14] == 2'h1)
        else $error("validity bits wrong");
    a_cmda_fixed: assert property (
        w == W_CMDA |-> (rdData_r & ~CMDA_CFG_MASK) == CMDA_FIXED_ONE)
        else $error("fixed bits of command set word wrong");
    a_read_answer: assert property (
        clkEn && rdEn |=> rdValid_r)
        else $error("read not answered");
    cover property (w == W_CMDA);
    cover property (!clkEn);
    cover property (timingValid_r ##1 !timingValid_r);
endmodule : identify_capability_asserts
bind identify_capability_words
    identify_capability_asserts identify_capability_asserts_i (
        .clk, .rst_n, .clkEn, .cfg, .rdEn, .rdIndex, .rdData_r,
        .rdValid_r, .timingValid_r);

// File: test/host_reader.sv
/* host model: single word reads; judges words 82..84 for feature
   indication. assumes a one-cycle answer */
`timescale 1ns/10ps
module host_reader (
    // answer
    input  wire logic        clk,
    input  wire logic [15:0] rdData_r,
    input  wire logic        rdValid_r,
    // request
    output logic             rdEn,
    output logic [7:0]       rdIndex,
    output logic             featShown
);
    initial begin
        rdEn = 1'b0;
        rdIndex = 8'h00;
        featShown = 1'b0;
    end
    task automatic readWord(input logic [7:0] idx, output logic [16:0] rsp);
        @(posedge clk);
        rdEn <= 1'b1;
        rdIndex <= idx;
        @(posedge clk);
        rdEn <= 1'b0;
        // a released index must not look like the last one
        rdIndex <= ~idx;
        @(negedge clk);
        rsp = {rdValid_r, rdData_r};
        // all-zero or all-ones means not indicated
        if (idx inside {8'h52, 8'h53, 8'h54})
            featShown = rdData_r != 16'h0000 && rdData_r != 16'hFFFF;
    endtask : readWord
endmodule : host_reader

// File: test/testbench.sv
/* bench for the capability words: word table under two configs,
   then freeze and reset cases. assumes the checker is bound */
`timescale 1ns/10ps
module testbench
    import identify_capability_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        clkEn = 1'b1;
    drive_cfg_t  cfg, full, bare;
    logic        rdEn, rdValid_r, timingValid_r, featShown;
    logic [7:0]  rdIndex;
    logic [15:0] rdData_r;
    logic [16:0] rsp;
    int          fails = 0;
    int          comparisons = 0;
    // index, word under full config, word under bare config
    logic [39:0] tab [15] = '{40'h3F_0407_0000, 40'h40_0003_0000,
        40'h41_0078_0000, 40'h42_0078_0000, 40'h43_0078_0000,
        40'h44_0078_0000, 40'h4B_0000_0000, 40'h4C_0706_0706,
        40'h4E_007E_007E, 40'h4F_0040_0040, 40'h52_744A_744A,
        40'h53_4009_4009, 40'h54_4000_4000, 40'h4D_0000_0000,
        40'h00_0000_0000};

    identify_capability_words identify_capability_words_i (.clk, .rst_n,
        .clkEn, .cfg, .rdEn, .rdIndex, .rdData_r, .rdValid_r,
        .timingValid_r);
    host_reader host_reader_i (.clk, .rdData_r, .rdValid_r, .rdEn,
        .rdIndex, .featShown);

    always #25 clk = ~clk;

    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic results;
        if (fails == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    initial begin
        full = '{3'h7, 2'h2, 1'b1, 2'h3, 16'h0078, 16'h0064, 16'h0064,
            16'h0078, 5'h1F, 16'hFFFF, 16'hFFFF, 16'h0041, 1'b1, 1'b0,
            1'b1, 1'b1};
        bare = full;
        bare.mdmaSupport = 3'h0;
        bare.mdmaSelValid = 1'b0;
        bare.pioAdvanced = 2'h0;
        cfg = full;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            cfg <= p ? bare : full;
            repeat (3) @(posedge clk);
            foreach (tab[i]) begin
                host_reader_i.readWord(tab[i][39:32], rsp);
                check(rsp, {1'b1, p ? tab[i][15:0] : tab[i][31:16]});
            end
            check({16'h0, timingValid_r}, p ? 17'h0 : 17'h1);
            check({16'h0, featShown}, 17'h1);
        end
        @(posedge clk);
        cfg <= full;
        clkEn <= 1'b0;
        host_reader_i.readWord(W_CMDA, rsp);
        check(rsp, 17'h0);
        @(posedge clk);
        clkEn <= 1'b1;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check({rdValid_r, rdData_r | {15'h0, timingValid_r}}, 17'h0);
        @(posedge clk);
        rst_n <= 1'b1;
        host_reader_i.readWord(W_MDMA, rsp);
        check(rsp, 17'h1_0407);
        check({16'h0, timingValid_r}, 17'h1);
        results;
    end

    initial begin
        repeat (2000) @(posedge clk);
        fails++;
        results;
    end
endmodule : testbench
